// ==== boot_mode_pkg.sv ====
/*
 * Constants shared by the boot mode selector: boot actions, initial program
 * counter values, strap encodings and synchroniser depth.
 * Assumes a single system clock and that straps are static around reset.
 */
package boot_mode_pkg;

    // Start-up actions chosen from the straps
    typedef enum logic [3:0] {
        ACT_BOOT_ROM,
        ACT_EXT_SLAVE_DIRECT,
        ACT_EXT_MASTER_DIRECT,
        ACT_EXT_SLAVE_PERIPH,
        ACT_EXT_MASTER_PERIPH,
        ACT_RESERVED,
        ACT_HALT_BUS_SLAVE,
        ACT_HALT_BUS_MASTER,
        ACT_HALT_BUS_OFF,
        ACT_EMULATOR,
        ACT_TRISTATE
    } boot_action_t;

    localparam logic [31:0] PC_BOOT_ROM = 32'hbfff_fffc;
    localparam logic [31:0] PC_EXTERNAL = 32'ha000_0000;
    localparam logic [31:0] PC_EMULATOR = 32'hbe00_0000;
    localparam logic [31:0] PC_NONE = 32'h0000_0000;

    localparam logic [2:0] CFG_ROM_A = 3'h0;
    localparam logic [2:0] CFG_ROM_B = 3'h1;
    localparam logic [2:0] CFG_ROM_C = 3'h2;
    localparam logic [2:0] CFG_EXT_DIRECT = 3'h4;
    localparam logic [2:0] CFG_EXT_PERIPH = 3'h5;

    localparam int CFG_MASTER_BIT = 3;
    localparam int CFG_WIDTH = 4;
    localparam int SYNC_STAGES = 3;
    // Input bundle: debug enable, break, four configuration bits
    localparam int IN_WIDTH = CFG_WIDTH + 2;
    // Consecutive agreeing samples before the strap value is trusted
    localparam logic [1:0] SETTLE_COUNT = 2'h2;

endpackage

// ==== boot_mode_selector.sv ====
/*
 * Boot mode selector: decodes the debug inputs and configuration straps
 * into a start-up action and the initial program counter.
 * The straps and the two debug inputs pass a three-stage synchroniser. The
 * result is captured once, after the synchronised bundle has agreed for a
 * few edges, and is then frozen until the next reset. The frozen action
 * drives a set of status flags, all held low before capture.
 * Reserved strap combinations decode to a harmless action with no program
 * counter and the bus unit off, so a misstrapped board is visible on a flag
 * rather than booting from an undefined source.
 * Assumes board straps and the debugger hold their levels steady around
 * the release of reset; everything runs on mclk_i.
 * Tri-state and deep sleep are reported only; pad control lives elsewhere.
 */
`timescale 1ns/1ps
module boot_mode_selector (
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic debug_enable_pin_i,
    input wire logic break_input_pin_i,
    input wire logic [3:0] cfg_i,
    output boot_mode_pkg::boot_action_t boot_action_o,
    output logic [31:0] initial_pc_o,
    output logic pc_valid_o,
    output logic boot_ready_o,
    output logic boot_from_rom_o,
    output logic boot_external_o,
    output logic ext_via_periph_bus_o,
    output logic halt_o,
    output logic bus_enable_o,
    output logic bus_master_o,
    output logic emulator_start_o,
    output logic tristate_o,
    output logic deep_sleep_o,
    output logic cfg_reserved_o
);
    logic [boot_mode_pkg::IN_WIDTH-1:0] pins_sync;
    logic pins_stable;
    logic [1:0] settle;
    logic captured;
    boot_mode_pkg::boot_action_t next_action;
    logic [31:0] next_pc;

    // Pins come from the board, so they cross into mclk_i first
    strap_sync #(
        .WIDTH(boot_mode_pkg::IN_WIDTH)
    ) u_sync (
        .mclk_i(mclk_i),
        .resetn_i(resetn_i),
        .pins_i({debug_enable_pin_i, break_input_pin_i, cfg_i}),
        .sync_o(pins_sync),
        .stable_o(pins_stable)
    );

    // Field selection from the synchronised bundle
    wire dbg_en = pins_sync[boot_mode_pkg::CFG_WIDTH+1];
    wire brk = pins_sync[boot_mode_pkg::CFG_WIDTH];
    wire [2:0] cfg_low = pins_sync[boot_mode_pkg::CFG_MASTER_BIT-1:0];
    wire cfg_master = pins_sync[boot_mode_pkg::CFG_MASTER_BIT];
    wire cfg_ext_any = (cfg_low == boot_mode_pkg::CFG_EXT_DIRECT) ||
                       (cfg_low == boot_mode_pkg::CFG_EXT_PERIPH);

    // Initial program counter for an action
    function automatic logic [31:0] pc_for(input boot_mode_pkg::boot_action_t act);
        case (act)
            boot_mode_pkg::ACT_BOOT_ROM: pc_for = boot_mode_pkg::PC_BOOT_ROM;
            boot_mode_pkg::ACT_EXT_SLAVE_DIRECT,
            boot_mode_pkg::ACT_EXT_MASTER_DIRECT,
            boot_mode_pkg::ACT_EXT_SLAVE_PERIPH,
            boot_mode_pkg::ACT_EXT_MASTER_PERIPH: pc_for = boot_mode_pkg::PC_EXTERNAL;
            boot_mode_pkg::ACT_EMULATOR: pc_for = boot_mode_pkg::PC_EMULATOR;
            default: pc_for = boot_mode_pkg::PC_NONE;
        endcase
    endfunction

    // Decode table; reserved combinations give a defined harmless action
    always_comb begin
        next_action = boot_mode_pkg::ACT_RESERVED;
        case ({dbg_en, brk})
            2'h3: begin
                case (cfg_low)
                    boot_mode_pkg::CFG_ROM_A,
                    boot_mode_pkg::CFG_ROM_B,
                    boot_mode_pkg::CFG_ROM_C: next_action = boot_mode_pkg::ACT_BOOT_ROM;
                    boot_mode_pkg::CFG_EXT_DIRECT: begin
                        next_action = cfg_master ? boot_mode_pkg::ACT_EXT_MASTER_DIRECT
                                                 : boot_mode_pkg::ACT_EXT_SLAVE_DIRECT;
                    end
                    boot_mode_pkg::CFG_EXT_PERIPH: begin
                        next_action = cfg_master ? boot_mode_pkg::ACT_EXT_MASTER_PERIPH
                                                 : boot_mode_pkg::ACT_EXT_SLAVE_PERIPH;
                    end
                    default: next_action = boot_mode_pkg::ACT_RESERVED;
                endcase
            end
            2'h1: begin
                if (cfg_ext_any && !cfg_master) begin
                    next_action = boot_mode_pkg::ACT_HALT_BUS_SLAVE;
                end else if (cfg_ext_any) begin
                    next_action = boot_mode_pkg::ACT_HALT_BUS_MASTER;
                end else begin
                    next_action = boot_mode_pkg::ACT_HALT_BUS_OFF;
                end
            end
            2'h0: next_action = boot_mode_pkg::ACT_EMULATOR;
            2'h2: next_action = boot_mode_pkg::ACT_TRISTATE;
            default: next_action = boot_mode_pkg::ACT_RESERVED;
        endcase
    end

    assign next_pc = pc_for(next_action);

    // Capture once after the synchroniser has settled, then freeze.
    // Waiting for agreeing samples keeps a strap caught mid-edge out.
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            settle <= '0;
            captured <= 1'b0;
            boot_action_o <= boot_mode_pkg::ACT_RESERVED;
            initial_pc_o <= boot_mode_pkg::PC_NONE;
        end else if (!captured) begin
            if (!pins_stable) begin
                settle <= '0;
            end else if (settle != boot_mode_pkg::SETTLE_COUNT) begin
                settle <= settle + 2'h1;
            end else begin
                captured <= 1'b1;
                boot_action_o <= next_action;
                initial_pc_o <= next_pc;
            end
        end
    end

    // Actions that leave the external bus unit as bus master
    function automatic logic is_master(input boot_mode_pkg::boot_action_t act);
        case (act)
            boot_mode_pkg::ACT_EXT_MASTER_DIRECT,
            boot_mode_pkg::ACT_EXT_MASTER_PERIPH,
            boot_mode_pkg::ACT_HALT_BUS_MASTER: is_master = 1'b1;
            default: is_master = 1'b0;
        endcase
    endfunction

    // Actions that leave the external bus unit enabled as slave
    function automatic logic is_slave(input boot_mode_pkg::boot_action_t act);
        case (act)
            boot_mode_pkg::ACT_EXT_SLAVE_DIRECT,
            boot_mode_pkg::ACT_EXT_SLAVE_PERIPH,
            boot_mode_pkg::ACT_HALT_BUS_SLAVE: is_slave = 1'b1;
            default: is_slave = 1'b0;
        endcase
    endfunction

    // Actions that fetch first code from external memory
    function automatic logic is_external(input boot_mode_pkg::boot_action_t act);
        case (act)
            boot_mode_pkg::ACT_EXT_SLAVE_DIRECT,
            boot_mode_pkg::ACT_EXT_MASTER_DIRECT,
            boot_mode_pkg::ACT_EXT_SLAVE_PERIPH,
            boot_mode_pkg::ACT_EXT_MASTER_PERIPH: is_external = 1'b1;
            default: is_external = 1'b0;
        endcase
    endfunction

    // External boots routed over the on-chip peripheral bus
    function automatic logic is_periph(input boot_mode_pkg::boot_action_t act);
        case (act)
            boot_mode_pkg::ACT_EXT_SLAVE_PERIPH,
            boot_mode_pkg::ACT_EXT_MASTER_PERIPH: is_periph = 1'b1;
            default: is_periph = 1'b0;
        endcase
    endfunction

    // Every flavour of halt, whatever the bus unit state
    function automatic logic is_halt(input boot_mode_pkg::boot_action_t act);
        case (act)
            boot_mode_pkg::ACT_HALT_BUS_SLAVE,
            boot_mode_pkg::ACT_HALT_BUS_MASTER,
            boot_mode_pkg::ACT_HALT_BUS_OFF: is_halt = 1'b1;
            default: is_halt = 1'b0;
        endcase
    endfunction

    // Chip floated and asleep; only a new reset brings it back
    function automatic logic is_standby(input boot_mode_pkg::boot_action_t act);
        case (act)
            boot_mode_pkg::ACT_TRISTATE: is_standby = 1'b1;
            default: is_standby = 1'b0;
        endcase
    endfunction

    // Raw decodes of the frozen action
    wire act_ms = is_master(boot_action_o);
    wire act_sl = is_slave(boot_action_o);
    wire act_ext = is_external(boot_action_o);
    wire act_per = is_periph(boot_action_o);
    wire act_halt = is_halt(boot_action_o);
    wire act_tri = is_standby(boot_action_o);

    // Status flags, all low until the capture has happened
    assign boot_ready_o = captured;
    assign pc_valid_o = captured && (initial_pc_o != boot_mode_pkg::PC_NONE);
    assign boot_from_rom_o = captured && (boot_action_o == boot_mode_pkg::ACT_BOOT_ROM);
    assign boot_external_o = captured && act_ext;
    assign ext_via_periph_bus_o = captured && act_per;
    assign halt_o = captured && act_halt;
    assign bus_enable_o = captured && (act_ms || act_sl);
    assign bus_master_o = captured && act_ms;
    assign emulator_start_o = captured && (boot_action_o == boot_mode_pkg::ACT_EMULATOR);
    assign tristate_o = captured && act_tri;
    assign deep_sleep_o = captured && act_tri;
    assign cfg_reserved_o = captured && (boot_action_o == boot_mode_pkg::ACT_RESERVED);
endmodule

// ==== boot_mode_selector_sva.sv ====
/* Checker for the boot mode selector outputs.
   Assumes it is bound to the selector and sees only its ports. */
`timescale 1ns/1ps
module boot_mode_selector_sva (
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic debug_enable_pin_i,
    input wire logic break_input_pin_i,
    input wire boot_mode_pkg::boot_action_t boot_action_o,
    input wire logic [31:0] initial_pc_o,
    input wire logic pc_valid_o,
    input wire logic boot_ready_o,
    input wire logic boot_from_rom_o,
    input wire logic boot_external_o,
    input wire logic halt_o,
    input wire logic emulator_start_o,
    input wire logic tristate_o,
    input wire logic deep_sleep_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);
    // Capture moment; straps are held steady by the board up to here
    sequence s_capture;
        $rose(boot_ready_o);
    endsequence
    sequence s_halt_straps;
        s_capture ##0 (!debug_enable_pin_i && break_input_pin_i);
    endsequence
    a_ready_bound: assert property ($rose(resetn_i) |-> ##[1:8] boot_ready_o)
        else $error("boot ready late");
    a_ready_holds: assert property (boot_ready_o |=> boot_ready_o)
        else $error("boot ready dropped");
    a_result_frozen: assert property (boot_ready_o |=> $stable(boot_action_o) && $stable(initial_pc_o))
        else $error("boot result moved");
    a_rom_pc: assert property (boot_from_rom_o |-> initial_pc_o == 32'hbfff_fffc)
        else $error("rom pc wrong");
    a_ext_pc: assert property (boot_external_o |-> initial_pc_o == 32'ha000_0000)
        else $error("external pc wrong");
    a_emu_pc: assert property (emulator_start_o |-> initial_pc_o == 32'hbe00_0000)
        else $error("emulator pc wrong");
    a_emu_decode: assert property (s_capture |-> emulator_start_o == (!debug_enable_pin_i && !break_input_pin_i))
        else $error("emulator decode wrong");
    a_halt_decode: assert property (s_halt_straps |-> halt_o && !pc_valid_o)
        else $error("halt decode wrong");
    a_tristate_sleep: assert property (s_capture |-> tristate_o == (debug_enable_pin_i && !break_input_pin_i) && deep_sleep_o == tristate_o && !(tristate_o && pc_valid_o))
        else $error("tristate without sleep");
endmodule
bind boot_mode_selector boot_mode_selector_sva u_sva (.*);

// ==== boot_mode_selector_tb_top.sv ====
/* Self-checking bench: sweeps every strap combination through reset and capture.
   Assumes the board model drives the straps and a 25 MHz mclk_i. */
`timescale 1ns/1ps
`define CHK(n, e, s) begin cmp_count++; if ((e) !== (s)) begin miscompares++; \
    $display("[FAIL] %s exp %0h got %0h", n, e, s); end end
module boot_mode_selector_tb_top;
    import boot_mode_pkg::*;
    logic mclk_i = 0, resetn_i = 0, alw = 1, de, br, rdy, rom, ext, per, hlt, ben, bms, emu, trs, slp;
    logic pcv, rsv;
    logic [5:0] set = 6'h00;
    logic [3:0] cfg;
    logic [31:0] pc;
    boot_action_t act;
    int miscompares = 0, cmp_count = 0, cyc = 0, seed = 45, i;
    always #20 mclk_i = ~mclk_i;
    strap_board board (.mclk_i(mclk_i), .set_i(set), .allow_reserved_i(alw),
        .debug_enable_pin_o(de), .break_input_pin_o(br), .cfg_o(cfg));
    boot_mode_selector dut (.mclk_i(mclk_i), .resetn_i(resetn_i), .debug_enable_pin_i(de),
        .break_input_pin_i(br), .cfg_i(cfg), .boot_action_o(act), .initial_pc_o(pc),
        .pc_valid_o(pcv), .boot_ready_o(rdy), .boot_from_rom_o(rom), .boot_external_o(ext),
        .ext_via_periph_bus_o(per), .halt_o(hlt), .bus_enable_o(ben), .bus_master_o(bms),
        .emulator_start_o(emu), .tristate_o(trs), .deep_sleep_o(slp), .cfg_reserved_o(rsv));
    // Reference decode of the strap table, kept apart from the design
    function automatic int exp_act(int d, int b, int c);
        int lo = c & 7;
        int m = (c >> 3) & 1;
        if (d && b) begin
            if (lo < 3) return ACT_BOOT_ROM;
            if (lo == 4) return m ? ACT_EXT_MASTER_DIRECT : ACT_EXT_SLAVE_DIRECT;
            if (lo == 5) return m ? ACT_EXT_MASTER_PERIPH : ACT_EXT_SLAVE_PERIPH;
            return ACT_RESERVED;
        end
        if (b) return (lo == 4 || lo == 5) ? (m ? ACT_HALT_BUS_MASTER : ACT_HALT_BUS_SLAVE)
            : ACT_HALT_BUS_OFF;
        return d ? ACT_TRISTATE : ACT_EMULATOR;
    endfunction
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // One boot: reset with straps, wait for capture, check, then disturb the pins
    task automatic run(input logic [5:0] v);
        int w = 0;
        boot_action_t ea;
        logic [31:0] ep;
        @(posedge mclk_i);
        resetn_i <= 1'b0;
        set <= v;
        repeat (3) @(posedge mclk_i);
        resetn_i <= 1'b1;
        while (rdy !== 1'b1 && w < 10) begin @(posedge mclk_i); w++; end
        #1;
        ea = boot_action_t'(exp_act(de, br, cfg));
        ep = (ea == ACT_BOOT_ROM) ? PC_BOOT_ROM : (ea == ACT_EMULATOR) ? PC_EMULATOR :
            (ea inside {[ACT_EXT_SLAVE_DIRECT:ACT_EXT_MASTER_PERIPH]}) ? PC_EXTERNAL : PC_NONE;
        `CHK("action", ea, act)
        `CHK("pc", ep, pc)
        `CHK("master", ea inside {ACT_EXT_MASTER_DIRECT, ACT_EXT_MASTER_PERIPH, ACT_HALT_BUS_MASTER}, bms)
        `CHK("periph", ea inside {ACT_EXT_SLAVE_PERIPH, ACT_EXT_MASTER_PERIPH}, per)
        `CHK("halt", ea inside {[ACT_HALT_BUS_SLAVE:ACT_HALT_BUS_OFF]}, hlt)
        `CHK("tristate", ea == ACT_TRISTATE, trs)
        `CHK("sleep", ea == ACT_TRISTATE, slp)
        `CHK("rom", ea == ACT_BOOT_ROM, rom)
        `CHK("external", ea inside {[ACT_EXT_SLAVE_DIRECT:ACT_EXT_MASTER_PERIPH]}, ext)
        `CHK("bus on", ea inside {[ACT_EXT_SLAVE_DIRECT:ACT_EXT_MASTER_PERIPH], ACT_HALT_BUS_SLAVE, ACT_HALT_BUS_MASTER}, ben)
        `CHK("emulator", ea == ACT_EMULATOR, emu)
        `CHK("pc valid", ep != PC_NONE, pcv)
        `CHK("reserved", ea == ACT_RESERVED, rsv)
        `CHK("ready", 1'b1, rdy)
        @(posedge mclk_i);
        set <= 6'($random(seed));
        repeat (8) @(posedge mclk_i);
        `CHK("held", ea, act)
        `CHK("held pc", ep, pc)
    endtask
    // Timeout well above 65 boots of about 20 cycles each
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc > 3000) begin miscompares++; test_done; end
    end
    initial begin
        repeat (10) @(posedge mclk_i);
        for (i = 0; i < 64; i++) run(6'(i));
        alw <= 1'b0;
        run(6'h37);
        test_done;
    end
endmodule

// ==== strap_board.sv ====
/* Board straps and debugger levels that feed the boot mode selector.
   Assumes the bench names the wanted levels and the model updates them on mclk_i. */
`timescale 1ns/1ps
module strap_board (
    input wire logic mclk_i,
    input wire logic [5:0] set_i,
    input wire logic allow_reserved_i,
    output logic debug_enable_pin_o,
    output logic break_input_pin_o,
    output logic [3:0] cfg_o
);
    logic bad;
    // Unless allow_reserved_i is high, the board never straps a reserved boot source
    assign bad = set_i[5] & set_i[4] & (set_i[2:0] inside {3'h3, 3'h6, 3'h7});
    // Levels move just after an edge, like a debugger pod re-driving pins
    always @(posedge mclk_i) begin
        {debug_enable_pin_o, break_input_pin_o} <= set_i[5:4];
        cfg_o <= (bad && !allow_reserved_i) ? {set_i[3], 3'h0} : set_i[3:0];
    end
endmodule

// ==== strap_sync.sv ====
/*
 * Three-stage synchroniser for a bundle of pin inputs.
 * Assumes the pins are asynchronous to mclk_i; the output changes only
 * once the second and third stages agree.
 */
`timescale 1ns/1ps
module strap_sync #(
    parameter int WIDTH = 6
) (
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic [WIDTH-1:0] pins_i,
    output logic [WIDTH-1:0] sync_o,
    output logic stable_o
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;
    wire agree = (stage2 == stage3);

    // Stage one feeds only stage two, to keep metastability contained
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
            sync_o <= '0;
        end else begin
            stage1 <= pins_i;
            stage2 <= stage1;
            stage3 <= stage2;
            if (agree) begin
                sync_o <= stage3;
            end
        end
    end

    assign stable_o = agree;
endmodule
